// file: hdl/cief_params.svh
// How it works
// - Bits 31..27 enable five requests: four error classes and bus wake-up
// - Bit 30 enables bus wake-up request
// - Bit 19 mode change, bit 18 timestamp
// - Bit 17 receive buffer, bit 16 transmit
// - Invalid message event sets flag bit 15
// - System error flag cleared only by enable toggle
// - Unimplemented bits ignore writes, read zero
`ifndef CIEF_PARAMS_SVH
`define CIEF_PARAMS_SVH

// ****************************************
// Register map
// ****************************************
`define CIEF_ADDR_INT 12'h000
`define CIEF_ADDR_CTRL 12'h004
`define CIEF_ADDR_STAT 12'h008
`define CIEF_ADDR_MASK 12'h00C
`define CIEF_RESET_WORD 32'h00000000
`define CIEF_NSRC 9
`define CIEF_IMPL_FLAGS 16'hF80F
`define CIEF_SERR_KEEP 16'h1000

// ****************************************
// Field positions
// ****************************************
`define CIEF_EN_HI_MASK 32'hF8000000
`define CIEF_EN_LO_MASK 32'h000F0000
`define CIEF_FLAG_SHIFT 16
`define CIEF_SERR_FLAG_BIT 12
`define CIEF_CTRL_ON_BIT 15
`define CIEF_EVT_ON_CLEAR 0
`define CIEF_EVT_ON_SET 1
`define CIEF_NEVT 2

`endif

// file: hdl/cief_pkg.sv
package cief_pkg;
    typedef struct packed {
        logic [15:0] en_reg;
        logic [15:0] flag_reg;
        logic on_reg;
        logic [1:0] evt_stat_reg;
        logic [1:0] evt_mask_reg;
        logic [31:0] prdata_reg;
        logic pslverr_reg;
        logic pready_reg;
        logic irq_reg;
        logic sys_irq_reg;
    } cief_state_t;
endpackage

// file: hdl/cief_top.sv
`timescale 1ns/1ps
`include "cief_params.svh"
module cief_top
    import cief_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [15:0] evt_set,
    output logic can_irq,
    output logic sys_irq
);
    // evt_set uses flag layout: bit 15 invalid msg, 14 wake, 13 bus err,
    // 12 system err, 11 rx overflow, 3 mode, 2 timestamp, 1 rx buf, 0 tx buf.

    cief_state_t st_reg;
    cief_state_t st_next;

    logic wr_acc;
    logic rd_acc;
    logic acc_wait;
    logic addr_ok;
    logic int_wr;
    logic [15:0] impl_mask;
    logic [15:0] wr_en;
    logic [15:0] wr_flag;
    logic [15:0] flags_n;
    logic [31:0] int_word;
    logic on_new;
    logic [1:0] evt_now;

    // ****************************************
    // Bus decode
    // ****************************************
    // One wait state: pready comes from a flop, so every access takes two edges
    assign acc_wait = psel & penable & ~st_reg.pready_reg;
    // Writes land on the edge where the master sees pready high
    assign wr_acc = psel & penable & pwrite & st_reg.pready_reg;
    // Reads are looked up in the wait cycle so prdata stands at the pready edge
    assign rd_acc = acc_wait & ~pwrite;
    assign addr_ok = paddr == `CIEF_ADDR_INT || paddr == `CIEF_ADDR_CTRL
                     || paddr == `CIEF_ADDR_STAT || paddr == `CIEF_ADDR_MASK;
    assign int_wr = wr_acc && paddr == `CIEF_ADDR_INT;
    assign impl_mask = `CIEF_IMPL_FLAGS;
    assign wr_en = pwdata[31:16] & impl_mask;
    assign wr_flag = pwdata[15:0] & impl_mask;
    assign int_word = {st_reg.en_reg, st_reg.flag_reg};

    // ****************************************
    // Next state
    // ****************************************
    always_comb begin
        st_next = st_reg;
        on_new = st_reg.on_reg;
        st_next.pslverr_reg = 1'b0;
        st_next.pready_reg = acc_wait;
        if (wr_acc && paddr == `CIEF_ADDR_CTRL) begin
            on_new = pwdata[`CIEF_CTRL_ON_BIT];
        end
        st_next.on_reg = on_new;
        evt_now = 2'h0;
        evt_now[`CIEF_EVT_ON_CLEAR] = st_reg.on_reg & ~on_new;
        evt_now[`CIEF_EVT_ON_SET] = ~st_reg.on_reg & on_new;
        flags_n = st_reg.flag_reg;
        if (wr_acc && paddr == `CIEF_ADDR_INT) begin
            st_next.en_reg = wr_en;
            // Software may only clear flags; system error is excluded
            flags_n = st_reg.flag_reg & (wr_flag | `CIEF_SERR_KEEP);
        end
        // Off-then-on is the only path that drops the system error flag
        if (evt_now[`CIEF_EVT_ON_SET]) begin
            flags_n[`CIEF_SERR_FLAG_BIT] = 1'b0;
        end
        // Set wins over a same-cycle clear
        st_next.flag_reg = (flags_n | evt_set) & impl_mask;
        if (wr_acc && paddr == `CIEF_ADDR_MASK) begin
            st_next.evt_mask_reg = pwdata[1:0];
        end
        if (wr_acc && paddr == `CIEF_ADDR_STAT) begin
            st_next.evt_stat_reg = st_reg.evt_stat_reg & ~pwdata[1:0];
        end
        st_next.evt_stat_reg = st_next.evt_stat_reg | evt_now;
        if (rd_acc) begin
            unique case (paddr)
                `CIEF_ADDR_INT: st_next.prdata_reg = int_word;
                `CIEF_ADDR_CTRL: st_next.prdata_reg = 32'(st_reg.on_reg) << `CIEF_CTRL_ON_BIT;
                `CIEF_ADDR_STAT: st_next.prdata_reg = {30'h0, st_reg.evt_stat_reg};
                `CIEF_ADDR_MASK: st_next.prdata_reg = {30'h0, st_reg.evt_mask_reg};
                default: begin
                    st_next.prdata_reg = 32'h00000000;
                    st_next.pslverr_reg = 1'b1;
                end
            endcase
        end else if (acc_wait && !addr_ok) begin
            st_next.pslverr_reg = 1'b1;
        end
        st_next.irq_reg = |(st_next.flag_reg & st_next.en_reg);
        st_next.sys_irq_reg = |(st_next.evt_stat_reg & st_next.evt_mask_reg);
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    assign prdata = st_reg.prdata_reg;
    assign pslverr = st_reg.pslverr_reg;
    assign pready = st_reg.pready_reg;
    assign can_irq = st_reg.irq_reg;
    assign sys_irq = st_reg.sys_irq_reg;

    // ****************************************
    // Checks
    // ****************************************
    // The irq flop is loaded from the next state, so it matches the
    // registered flags and enables in the same cycle
    AST_IVR_SET: assert property (@(posedge pclk) disable iff (!presetn)
        evt_set[15] |=> st_reg.flag_reg[15])
        else $error("invalid msg flag not set");

    AST_SERR_HOLD: assert property (@(posedge pclk) disable iff (!presetn)
        st_reg.flag_reg[12] && !evt_now[`CIEF_EVT_ON_SET] |=> st_reg.flag_reg[12])
        else $error("system error flag lost");

    AST_SERR_CLR: assert property (@(posedge pclk) disable iff (!presetn)
        evt_now[`CIEF_EVT_ON_SET] && !evt_set[12] |=> !st_reg.flag_reg[12])
        else $error("system error flag not cleared");

    AST_SERR_NO_SW_CLR: assert property (@(posedge pclk) disable iff (!presetn)
        int_wr && st_reg.flag_reg[12] && !pwdata[12] && !evt_now[`CIEF_EVT_ON_SET] |=> st_reg.flag_reg[12])
        else $error("system error flag cleared by write");

    AST_UNIMPL: assert property (@(posedge pclk) disable iff (!presetn)
        (int_word & 32'h07F007F0) == 32'h00000000)
        else $error("unimplemented bit set");

    AST_RD_INT: assert property (@(posedge pclk) disable iff (!presetn)
        rd_acc && paddr == `CIEF_ADDR_INT |=> prdata == $past(int_word))
        else $error("interrupt register read wrong");

    AST_RD_UNMAPPED: assert property (@(posedge pclk) disable iff (!presetn)
        rd_acc && !addr_ok |=> prdata == 32'h00000000)
        else $error("unmapped read not zero");

    AST_EN_WR: assert property (@(posedge pclk) disable iff (!presetn)
        int_wr |=> st_reg.en_reg == $past(wr_en))
        else $error("enable write lost");

    AST_EN_HI: assert property (@(posedge pclk) disable iff (!presetn)
        int_wr |=> st_reg.en_reg[15:11] == $past(pwdata[31:27]))
        else $error("error class enables wrong");

    AST_WAKE_EN: assert property (@(posedge pclk) disable iff (!presetn)
        st_reg.en_reg[14] && st_reg.flag_reg[14] |-> can_irq)
        else $error("wake irq missing");

    AST_MODE_EN: assert property (@(posedge pclk) disable iff (!presetn)
        !st_reg.en_reg[3] && st_reg.flag_reg == 16'h0008 |-> !can_irq)
        else $error("mode irq leak");

    AST_TMR_EN: assert property (@(posedge pclk) disable iff (!presetn)
        int_wr |=> st_reg.en_reg[2] == $past(pwdata[18]))
        else $error("timestamp enable wrong");

    AST_BUF_EN: assert property (@(posedge pclk) disable iff (!presetn)
        int_wr |=> st_reg.en_reg[1:0] == $past(pwdata[17:16]))
        else $error("buffer enables wrong");

    AST_IRQ: assert property (@(posedge pclk) disable iff (!presetn)
        can_irq == |(st_reg.flag_reg & st_reg.en_reg))
        else $error("irq mismatch");

    AST_IRQ_RISE: assert property (@(posedge pclk) disable iff (!presetn)
        $rose(can_irq) |-> |(st_reg.flag_reg & st_reg.en_reg))
        else $error("irq rose without source");

    // ****************************************
    // Bus handshake checks
    // ****************************************
    AST_PREADY_WAIT: assert property (@(posedge pclk) disable iff (!presetn)
        psel && penable && !pready |=> pready)
        else $error("pready missing after wait");

    AST_PREADY_ONE: assert property (@(posedge pclk) disable iff (!presetn)
        pready |=> !pready)
        else $error("pready held too long");

    AST_PREADY_IDLE: assert property (@(posedge pclk) disable iff (!presetn)
        !psel |=> !pready)
        else $error("pready without select");

    AST_ERR_UNMAPPED: assert property (@(posedge pclk) disable iff (!presetn)
        acc_wait && !addr_ok |=> pslverr)
        else $error("unmapped access without error");

    AST_ERR_MAPPED: assert property (@(posedge pclk) disable iff (!presetn)
        acc_wait && addr_ok |=> !pslverr)
        else $error("mapped access flagged error");

    AST_ERR_PAIRED: assert property (@(posedge pclk) disable iff (!presetn)
        pslverr |-> pready)
        else $error("error outside access end");

    AST_PRDATA_HOLD: assert property (@(posedge pclk) disable iff (!presetn)
        !rd_acc |=> $stable(prdata))
        else $error("read data moved");

    // ****************************************
    // Control and module status checks
    // ****************************************
    AST_ON_WR: assert property (@(posedge pclk) disable iff (!presetn)
        wr_acc && paddr == `CIEF_ADDR_CTRL |=> st_reg.on_reg == $past(pwdata[`CIEF_CTRL_ON_BIT]))
        else $error("module enable write lost");

    AST_ON_HOLD: assert property (@(posedge pclk) disable iff (!presetn)
        !(wr_acc && paddr == `CIEF_ADDR_CTRL) |=> $stable(st_reg.on_reg))
        else $error("module enable moved");

    AST_RD_CTRL: assert property (@(posedge pclk) disable iff (!presetn)
        rd_acc && paddr == `CIEF_ADDR_CTRL |=> prdata[`CIEF_CTRL_ON_BIT] == $past(st_reg.on_reg))
        else $error("control read wrong");

    AST_RD_STAT: assert property (@(posedge pclk) disable iff (!presetn)
        rd_acc && paddr == `CIEF_ADDR_STAT |=> prdata == {30'h0, $past(st_reg.evt_stat_reg)})
        else $error("status read wrong");

    AST_RD_MASK: assert property (@(posedge pclk) disable iff (!presetn)
        rd_acc && paddr == `CIEF_ADDR_MASK |=> prdata == {30'h0, $past(st_reg.evt_mask_reg)})
        else $error("mask read wrong");

    AST_MASK_WR: assert property (@(posedge pclk) disable iff (!presetn)
        wr_acc && paddr == `CIEF_ADDR_MASK |=> st_reg.evt_mask_reg == $past(pwdata[1:0]))
        else $error("mask write lost");

    AST_STAT_SET: assert property (@(posedge pclk) disable iff (!presetn)
        |evt_now |=> (st_reg.evt_stat_reg & $past(evt_now)) == $past(evt_now))
        else $error("status event lost");

    AST_STAT_W1C: assert property (@(posedge pclk) disable iff (!presetn)
        wr_acc && paddr == `CIEF_ADDR_STAT && evt_now == 2'h0 |=> (st_reg.evt_stat_reg & $past(pwdata[1:0])) == 2'h0)
        else $error("status bit not cleared");

    AST_SYS_IRQ: assert property (@(posedge pclk) disable iff (!presetn)
        sys_irq == |(st_reg.evt_stat_reg & st_reg.evt_mask_reg))
        else $error("module irq mismatch");

    AST_SYS_SRC: assert property (@(posedge pclk) disable iff (!presetn)
        $rose(sys_irq) |-> |st_reg.evt_stat_reg)
        else $error("module irq rose without source");

    // ****************************************
    // Per-source checks
    // ****************************************
    // Unimplemented slots get only the stuck-at-zero checks; the system
    // error slot skips the write-clear check since writes cannot clear it
    genvar gi;
    generate
        for (gi = 0; gi < `CIEF_FLAG_SHIFT; gi++) begin : g_src
            if (((`CIEF_IMPL_FLAGS >> gi) & 16'h0001) != 16'h0000) begin : g_impl
                AST_SRC_SET: assert property (@(posedge pclk) disable iff (!presetn)
                    evt_set[gi] |=> st_reg.flag_reg[gi])
                    else $error("event did not set its flag");

                AST_SRC_NO_SW_SET: assert property (@(posedge pclk) disable iff (!presetn)
                    !st_reg.flag_reg[gi] && !evt_set[gi] |=> !st_reg.flag_reg[gi])
                    else $error("flag set without event");

                AST_SRC_KEEP: assert property (@(posedge pclk) disable iff (!presetn)
                    st_reg.flag_reg[gi] && !int_wr && !evt_now[`CIEF_EVT_ON_SET] |=> st_reg.flag_reg[gi])
                    else $error("flag dropped on its own");

                AST_SRC_WR_KEEP: assert property (@(posedge pclk) disable iff (!presetn)
                    int_wr && pwdata[gi] && st_reg.flag_reg[gi] |=> st_reg.flag_reg[gi])
                    else $error("flag dropped by writing one");

                AST_SRC_EN_WR: assert property (@(posedge pclk) disable iff (!presetn)
                    int_wr |=> st_reg.en_reg[gi] == $past(pwdata[gi + `CIEF_FLAG_SHIFT]))
                    else $error("source enable write lost");

                AST_SRC_EN_HOLD: assert property (@(posedge pclk) disable iff (!presetn)
                    !int_wr |=> $stable(st_reg.en_reg[gi]))
                    else $error("source enable moved");

                AST_SRC_IRQ: assert property (@(posedge pclk) disable iff (!presetn)
                    st_reg.flag_reg[gi] && st_reg.en_reg[gi] |-> can_irq)
                    else $error("enabled flag without irq");

                if (gi != `CIEF_SERR_FLAG_BIT) begin : g_clr
                    AST_SRC_WR_CLR: assert property (@(posedge pclk) disable iff (!presetn)
                        int_wr && !pwdata[gi] && !evt_set[gi] |=> !st_reg.flag_reg[gi])
                        else $error("flag not cleared by writing zero");
                end
            end else begin : g_unused
                AST_SRC_ZERO: assert property (@(posedge pclk) disable iff (!presetn)
                    !st_reg.en_reg[gi] && !st_reg.flag_reg[gi])
                    else $error("unimplemented slot set");

                AST_SRC_WR_ZERO: assert property (@(posedge pclk) disable iff (!presetn)
                    int_wr |=> !st_reg.en_reg[gi] && !st_reg.flag_reg[gi])
                    else $error("unimplemented slot took a write");
            end
        end
    endgenerate

    // ****************************************
    // Coverage
    // ****************************************
    COV_IRQ: cover property (@(posedge pclk) disable iff (!presetn) $rose(can_irq));
    COV_TOGGLE: cover property (@(posedge pclk) disable iff (!presetn) evt_now[`CIEF_EVT_ON_SET]);
    COV_SETCLR: cover property (@(posedge pclk) disable iff (!presetn) wr_acc && |evt_set);
    COV_SERR_CLR: cover property (@(posedge pclk) disable iff (!presetn)
        st_reg.flag_reg[12] && evt_now[`CIEF_EVT_ON_SET]);
    COV_ERR: cover property (@(posedge pclk) disable iff (!presetn) pslverr);
endmodule // cief_top

// file: verification/cief_can_node.sv
`timescale 1ns/1ps
// ****
// Far-side event source
// ****
module cief_can_node (
    input wire logic pclk,
    input wire logic go,
    input wire logic [15:0] mask,
    output logic [15:0] evt_set
);
    // One-cycle pulse, so no event line stays high after its event
    always_ff @(posedge pclk) begin
        evt_set <= go ? mask : 16'h0000;
    end
endmodule // cief_can_node

// file: verification/cief_tb_top.sv
`timescale 1ns/1ps
module can_interrupt_enable_flags_tb_top;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, go = 0, pready, pslverr, can_irq, sys_irq, er;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic [15:0] mask = 16'h0, evt_set;
    int fail_count = 0, total_checks = 0;
    initial forever #10 pclk = ~pclk;
    cief_top dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .evt_set(evt_set), .can_irq(can_irq), .sys_irq(sys_irq));
    cief_can_node node_u (.pclk(pclk), .go(go), .mask(mask), .evt_set(evt_set));
    task close_out;
        $display("checks %0d mismatches %0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    task chk(input string nm, input logic [31:0] s, input logic [31:0] e);
        total_checks++;
        if (s !== e) begin
            fail_count++;
            $display("unexpected %s exp %h got %h", nm, e, s);
        end
    endtask
    // Read data and error are taken at the edge where pready is sampled high
    task bus(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge pclk) begin psel <= 1; pwrite <= w; paddr <= a; pwdata <= d; end
        @(posedge pclk) penable <= 1;
        do begin @(posedge pclk); n++; end while (pready !== 1'b1 && n < 8);
        if (n >= 8) begin fail_count++; close_out; end
        rd = prdata;
        er = pslverr;
        psel <= 0;
        penable <= 0;
    endtask
    task evt(input logic [15:0] m);
        @(posedge pclk) begin go <= 1; mask <= m; end
        @(posedge pclk) go <= 0;
        repeat (3) @(posedge pclk);
        #1;
    endtask
    task t_regs;
        bus(0, 12'h000, 0); chk("reset", rd, 32'h0);
        bus(1, 12'h000, 32'hFFFFFFFF); bus(0, 12'h000, 0);
        chk("enables", rd, 32'hF80F0000);
        bus(1, 12'h010, 32'hFFFFFFFF); chk("err", er, 1);
        bus(0, 12'h010, 0); chk("unmapped", rd, 0);
        $display("test regs done");
    endtask
    task t_flags;
        evt(16'hF80F); chk("irq", can_irq, 1);
        bus(0, 12'h000, 0); chk("flags", rd, 32'hF80FF80F);
        bus(1, 12'h000, 32'hF80F0000); bus(0, 12'h000, 0); chk("syserr", rd, 32'hF80F1000);
        bus(1, 12'h004, 0); bus(1, 12'h004, 32'h8000); bus(0, 12'h000, 0);
        chk("toggle", rd, 32'hF80F0000);
        $display("test flags done");
    endtask
    task t_irq;
        bus(1, 12'h000, 0); evt(16'h0001); chk("masked", can_irq, 0);
        bus(1, 12'h000, 32'h00010001); @(posedge pclk); #1 chk("unmasked", can_irq, 1);
        bus(1, 12'h008, 3); bus(1, 12'h00C, 3); bus(1, 12'h004, 0); @(posedge pclk);
        #1 chk("sys", sys_irq, 1);
        bus(0, 12'h008, 0); chk("stat", rd, 1);
        bus(1, 12'h008, 1); @(posedge pclk); #1 chk("sysclr", sys_irq, 0);
        $display("test irq done");
    endtask
    task t_reset;
        bus(1, 12'h000, 32'hFFFFFFFF); evt(16'hF80F);
        @(posedge pclk) presetn <= 0;
        @(posedge pclk) presetn <= 1;
        #1 chk("rst irq", can_irq, 0);
        bus(0, 12'h000, 0); chk("rst reg", rd, 32'h0);
        $display("test reset done");
    endtask
    initial begin
        repeat (2) @(posedge pclk);
        presetn <= 1;
        t_regs;
        t_flags;
        t_irq;
        t_reset;
        close_out;
    end
endmodule // can_interrupt_enable_flags_tb_top
